// file: verilog/bst_pkg.sv
// constants, instruction codes and controller states of the test access port
package bst_pkg;

  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int SYNC_STAGES = 2;

  // instruction codes, lsb first
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDCODE = 3'h1;
  localparam logic [2:0] INS_SAMPLE_HIZ = 3'h2;
  localparam logic [2:0] INS_RESERVED_BYPASS_ALIAS_A = 3'h3;
  localparam logic [2:0] INS_SAMPLE_PRELOAD = 3'h4;
  localparam logic [2:0] INS_PRIVATE_VENDOR_INSTRUCTION = 3'h5;
  localparam logic [2:0] INS_RESERVED_BYPASS_ALIAS_B = 3'h6;
  localparam logic [2:0] INS_BYPASS = 3'h7;

  localparam logic [2:0] IR_RESET_VAL = INS_IDCODE;
  localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;

  // identification word layout
  localparam int ID_PRESENCE_POS = 0;
  localparam int ID_VENDOR_LSB = 1;
  localparam int ID_VENDOR_MSB = 11;
  localparam logic [10:0] ID_VENDOR_DEF = 11'h2A5;  // arbitrary value

  // consecutive high mode-select edges that always reach reset
  localparam int TLR_TMS_ONES = 5;

  // pull-up level of undriven test inputs
  localparam logic PIN_PULL_LVL = 1'b1;

  typedef enum logic [15:0] {
    ST_TLR        = 16'h0001,
    ST_IDLE       = 16'h0002,
    ST_SEL_DR     = 16'h0004,
    ST_CAP_DR     = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPD_DR     = 16'h0100,
    ST_SEL_IR     = 16'h0200,
    ST_CAP_IR     = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPD_IR     = 16'h8000
  } bst_state_t;

endpackage

// file: verilog/bst_tap_fsm.sv
// sixteen-state test access controller stepped on test clock rising edges
`timescale 1ns/10ps
module bst_tap_fsm (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic tck_rise,
  input wire logic tms,
  output bst_pkg::bst_state_t state
);

  bst_pkg::bst_state_t state_r;
  bst_pkg::bst_state_t state_nxt;

  assign state = state_r;

  // every state returns to reset within five high mode-select edges
  always_comb begin
    case (state_r)
      bst_pkg::ST_TLR: state_nxt = tms ? bst_pkg::ST_TLR : bst_pkg::ST_IDLE;
      bst_pkg::ST_IDLE: state_nxt = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_DR: state_nxt = tms ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
      bst_pkg::ST_CAP_DR: state_nxt = tms ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
      bst_pkg::ST_SHIFT_DR: state_nxt = tms ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
      bst_pkg::ST_EXIT1_DR: state_nxt = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAUSE_DR;
      bst_pkg::ST_PAUSE_DR: state_nxt = tms ? bst_pkg::ST_EXIT2_DR : bst_pkg::ST_PAUSE_DR;
      bst_pkg::ST_EXIT2_DR: state_nxt = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SHIFT_DR;
      bst_pkg::ST_UPD_DR: state_nxt = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_IR: state_nxt = tms ? bst_pkg::ST_TLR : bst_pkg::ST_CAP_IR;
      bst_pkg::ST_CAP_IR: state_nxt = tms ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
      bst_pkg::ST_SHIFT_IR: state_nxt = tms ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
      bst_pkg::ST_EXIT1_IR: state_nxt = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAUSE_IR;
      bst_pkg::ST_PAUSE_IR: state_nxt = tms ? bst_pkg::ST_EXIT2_IR : bst_pkg::ST_PAUSE_IR;
      bst_pkg::ST_EXIT2_IR: state_nxt = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SHIFT_IR;
      bst_pkg::ST_UPD_IR: state_nxt = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      default: state_nxt = bst_pkg::ST_TLR;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= bst_pkg::ST_TLR;
    end else if (tck_rise) begin
      state_r <= state_nxt;
    end
  end

endmodule

// file: verilog/bst_scan_ring.sv
// boundary scan register: capture, serial shift and parallel update stage
`timescale 1ns/10ps
module bst_scan_ring #(
  parameter int RING_LEN = 8,
  parameter int PIN_CELLS = 6
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic capture,
  input wire logic shift,
  input wire logic update,
  input wire logic tdi,
  input wire logic [PIN_CELLS-1:0] pin_lvl,
  output logic scan_out,
  output logic [PIN_CELLS-1:0] par_out
);

  logic [RING_LEN-1:0] cell_r;
  logic [PIN_CELLS-1:0] upd_r;

  assign scan_out = cell_r[0];
  assign par_out = upd_r;

  genvar gi;
  generate
    for (gi = 0; gi < RING_LEN; gi++) begin : g_cell
      logic cap_val;
      logic shift_in;
      // cells with no pin behind them always capture a one
      if (gi < PIN_CELLS) begin : g_pin
        assign cap_val = pin_lvl[gi];
      end else begin : g_fill
        assign cap_val = 1'b1;
      end
      if (gi == RING_LEN - 1) begin : g_top
        assign shift_in = tdi;
      end else begin : g_mid
        assign shift_in = cell_r[gi+1];
      end
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          cell_r[gi] <= 1'b1;
        end else if (capture) begin
          cell_r[gi] <= cap_val;
        end else if (shift) begin
          cell_r[gi] <= shift_in;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      upd_r <= '0;
    end else if (update) begin
      upd_r <= cell_r[PIN_CELLS-1:0];
    end
  end

endmodule

// file: verilog/bst_boundary_scan_tap.sv
// test access port of the memory: pin sampling, instruction and data paths
`timescale 1ns/10ps
module bst_boundary_scan_tap #(
  parameter int RING_LEN = 8,
  parameter int PIN_CELLS = 6,
  parameter logic [10:0] VENDOR_CODE = bst_pkg::ID_VENDOR_DEF
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic tck_pin,
  input wire logic tms_pin,
  input wire logic tdi_pin,
  output logic tdo,
  output logic tdo_oe_n,
  input wire logic [PIN_CELLS-1:0] mem_pin_lvl,
  output logic [PIN_CELLS-1:0] ring_drive_data,
  output logic ring_drive_en,
  output logic mem_out_hiz,
  output logic [bst_pkg::IR_W-1:0] active_instr
);

  localparam logic [bst_pkg::ID_W-1:0] ID_WORD = {
    {(bst_pkg::ID_W - bst_pkg::ID_VENDOR_MSB - 1){1'b0}},
    VENDOR_CODE,
    1'b1
  };

  // data register selected by an instruction
  typedef enum logic [2:0] {
    DSEL_BYPASS = 3'h1,
    DSEL_IDENT  = 3'h2,
    DSEL_RING   = 3'h4
  } bst_dsel_t;

  function automatic bst_dsel_t dsel_of(input logic [bst_pkg::IR_W-1:0] ins);
    bst_dsel_t d;
    d = DSEL_BYPASS;
    case (ins)
      bst_pkg::INS_EXTEST: d = DSEL_RING;
      bst_pkg::INS_SAMPLE_HIZ: d = DSEL_RING;
      bst_pkg::INS_SAMPLE_PRELOAD: d = DSEL_RING;
      bst_pkg::INS_IDCODE: d = DSEL_IDENT;
      bst_pkg::INS_RESERVED_BYPASS_ALIAS_A: d = DSEL_BYPASS;
      bst_pkg::INS_RESERVED_BYPASS_ALIAS_B: d = DSEL_BYPASS;
      bst_pkg::INS_PRIVATE_VENDOR_INSTRUCTION: d = DSEL_BYPASS;
      bst_pkg::INS_BYPASS: d = DSEL_BYPASS;
      default: d = DSEL_BYPASS;
    endcase
    return d;
  endfunction

  // two-stage synchronisers; the pull-up level is the reset value of mode select and data in so a
  // floating pin and a pin not yet sampled both read high
  logic [bst_pkg::SYNC_STAGES-1:0] tck_sync_r;
  logic [bst_pkg::SYNC_STAGES-1:0] tms_sync_r;
  logic [bst_pkg::SYNC_STAGES-1:0] tdi_sync_r;
  logic tck_prev_r;
  logic [PIN_CELLS-1:0] pin_s1_r;
  logic [PIN_CELLS-1:0] pin_s2_r;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tck_sync_r <= '0;
      tck_prev_r <= 1'b0;
      tms_sync_r <= {bst_pkg::SYNC_STAGES{bst_pkg::PIN_PULL_LVL}};
      tdi_sync_r <= {bst_pkg::SYNC_STAGES{bst_pkg::PIN_PULL_LVL}};
    end else begin
      tck_sync_r <= {tck_sync_r[0], tck_pin};
      tck_prev_r <= tck_sync_r[1];
      tms_sync_r <= {tms_sync_r[0], tms_pin};
      tdi_sync_r <= {tdi_sync_r[0], tdi_pin};
    end
  end

  // memory pin levels cross from the memory clock; capture is only
  // repeatable when the system holds them still around it
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= mem_pin_lvl;
      pin_s2_r <= pin_s1_r;
    end
  end

  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;

  // no port activity without test clock edges; only the pin synchronisers keep sampling every system clock
  assign tck_rise = tck_sync_r[1] & ~tck_prev_r;
  assign tck_fall = ~tck_sync_r[1] & tck_prev_r;
  assign tms = tms_sync_r[1];
  assign tdi = tdi_sync_r[1];

  bst_pkg::bst_state_t state;

  bst_tap_fsm u_fsm (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .tck_rise(tck_rise),
    .tms(tms),
    .state(state)
  );

  logic [bst_pkg::IR_W-1:0] ir_shift_r;
  logic [bst_pkg::IR_W-1:0] ir_active_r;
  logic bypass_r;
  logic [bst_pkg::ID_W-1:0] ident_r;
  logic tdo_r;
  logic tdo_oe_n_r;

  logic in_tlr;
  logic cap_dr_edge;
  logic shift_dr_edge;
  logic shift_ir_edge;
  logic upd_ir_fall;
  bst_dsel_t dsel;

  assign in_tlr = (state == bst_pkg::ST_TLR);
  assign cap_dr_edge = tck_rise & (state == bst_pkg::ST_CAP_DR);
  assign shift_dr_edge = tck_rise & (state == bst_pkg::ST_SHIFT_DR);
  assign shift_ir_edge = tck_rise & (state == bst_pkg::ST_SHIFT_IR);
  assign upd_ir_fall = tck_fall & (state == bst_pkg::ST_UPD_IR);
  assign dsel = dsel_of(ir_active_r);

  // instruction shift stage and the held instruction
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ir_shift_r <= bst_pkg::IR_RESET_VAL;
    end else if (tck_rise && state == bst_pkg::ST_CAP_IR) begin
      ir_shift_r <= {ir_shift_r[bst_pkg::IR_W-1:2], bst_pkg::IR_CAPTURE_LOW};
    end else if (shift_ir_edge) begin
      ir_shift_r <= {tdi, ir_shift_r[bst_pkg::IR_W-1:1]};
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ir_active_r <= bst_pkg::IR_RESET_VAL;
    end else if (in_tlr) begin
      ir_active_r <= bst_pkg::IR_RESET_VAL;
    end else if (upd_ir_fall) begin
      ir_active_r <= ir_shift_r;
    end
  end

  // one-bit bypass stage; captures zero as is customary for this stage
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bypass_r <= 1'b0;
    end else if (cap_dr_edge && dsel == DSEL_BYPASS) begin
      bypass_r <= 1'b0;
    end else if (shift_dr_edge && dsel == DSEL_BYPASS) begin
      bypass_r <= tdi;
    end
  end

  // identification word, shifted toward bit 0 so bit 0 leaves first
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ident_r <= ID_WORD;
    end else if (cap_dr_edge && dsel == DSEL_IDENT) begin
      ident_r <= ID_WORD;
    end else if (shift_dr_edge && dsel == DSEL_IDENT) begin
      ident_r <= {tdi, ident_r[bst_pkg::ID_W-1:1]};
    end
  end

  logic ring_out;
  logic ring_cap;
  logic ring_shift;
  logic ring_upd;

  // capture follows the ring for all three ring instructions alike
  assign ring_cap = cap_dr_edge & (dsel == DSEL_RING);
  assign ring_shift = shift_dr_edge & (dsel == DSEL_RING);
  // parallel load on the falling edge in instruction update, as the part does,
  // rather than in data update
  assign ring_upd = upd_ir_fall & (ir_shift_r == bst_pkg::INS_EXTEST);

  bst_scan_ring #(
    .RING_LEN(RING_LEN),
    .PIN_CELLS(PIN_CELLS)
  ) u_ring (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .capture(ring_cap),
    .shift(ring_shift),
    .update(ring_upd),
    .tdi(tdi),
    .pin_lvl(pin_s2_r),
    .scan_out(ring_out),
    .par_out(ring_drive_data)
  );

  // serial output moves on the falling edge, enabled only while shifting
  logic out_bit;

  always_comb begin
    out_bit = bypass_r;
    if (state == bst_pkg::ST_SHIFT_IR) begin
      out_bit = ir_shift_r[0];
    end else if (dsel == DSEL_IDENT) begin
      out_bit = ident_r[0];
    end else if (dsel == DSEL_RING) begin
      out_bit = ring_out;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tdo_r <= 1'b0;
      tdo_oe_n_r <= 1'b1;
    end else if (tck_fall) begin
      if (state == bst_pkg::ST_SHIFT_IR || state == bst_pkg::ST_SHIFT_DR) begin
        tdo_r <= out_bit;
        tdo_oe_n_r <= 1'b0;
      end else begin
        tdo_oe_n_r <= 1'b1;
      end
    end
  end

  assign tdo = tdo_r;
  assign tdo_oe_n = tdo_oe_n_r;
  assign active_instr = ir_active_r;
  // external test drives outputs but leaves the memory inputs alone
  assign ring_drive_en = (ir_active_r == bst_pkg::INS_EXTEST);
  assign mem_out_hiz = (ir_active_r == bst_pkg::INS_SAMPLE_HIZ);

endmodule

// file: dv/bst_tap_monitor.sv
// assertion checker on the test access port top-level pins
`timescale 1ns/10ps
module bst_tap_monitor #(
  parameter int PIN_CELLS = 6
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic tck_pin,
  input wire logic tms_pin,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  input wire logic [PIN_CELLS-1:0] ring_drive_data,
  input wire logic ring_drive_en,
  input wire logic mem_out_hiz,
  input wire logic [bst_pkg::IR_W-1:0] active_instr
);
  logic tck_q;
  logic [2:0] ones;
  logic [3:0] quiet;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // raw pin edges; the design's sync delay is absorbed by the delay windows
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tck_q <= 1'b0;
      ones <= 3'h0;
      quiet <= 4'h0;
    end else begin
      tck_q <= tck_pin;
      quiet <= (tck_pin != tck_q) ? 4'h0 : ((quiet == 4'hF) ? quiet : quiet + 4'h1);
      if (tck_pin && !tck_q) ones <= tms_pin ? ((ones == 3'h7) ? ones : ones + 3'h1) : 3'h0;
    end
  end
  sequence s_low_settled;
    !tck_pin && !$past(tck_pin, 2);
  endsequence
  property p_tdo_fall; $changed(tdo) |-> s_low_settled; endproperty
  a_tdo_fall: assert property (p_tdo_fall)
    else $error("tdo moved away from a test clock fall");
  property p_oe_fall; $changed(tdo_oe_n) |-> s_low_settled; endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("tdo enable moved away from a test clock fall");
  property p_quiet; quiet > 4'h9 |-> $stable(active_instr) && $stable(tdo_oe_n); endproperty
  a_quiet: assert property (p_quiet)
    else $error("port changed without test clock edges");
  property p_five; $rose(ones >= 3'h5) |-> ##[1:8] active_instr == bst_pkg::INS_IDCODE; endproperty
  a_five: assert property (p_five)
    else $error("five high mode-select rises did not reset the port");
  property p_oe_off; ones >= 3'h3 |-> tdo_oe_n; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("tdo enabled outside shift states");
  property p_rst; $fell(sys_rst) |-> active_instr == bst_pkg::INS_IDCODE && tdo_oe_n; endproperty
  a_rst: assert property (p_rst)
    else $error("wrong values after reset");
  property p_upd; $changed(active_instr) && active_instr != 3'h1 |-> s_low_settled; endproperty
  a_upd: assert property (p_upd)
    else $error("instruction changed off an update fall");
  property p_ext; ring_drive_en == (active_instr == bst_pkg::INS_EXTEST); endproperty
  a_ext: assert property (p_ext)
    else $error("ring drive enable does not follow the instruction");
  property p_hiz; mem_out_hiz == (active_instr == bst_pkg::INS_SAMPLE_HIZ); endproperty
  a_hiz: assert property (p_hiz)
    else $error("output high impedance does not follow the instruction");
  property p_drv; $changed(ring_drive_data) |-> active_instr == 3'h0 ##0 s_low_settled; endproperty
  a_drv: assert property (p_drv)
    else $error("ring drive data changed outside external test update");
endmodule

bind bst_boundary_scan_tap bst_tap_monitor #(.PIN_CELLS(PIN_CELLS)) u_mon (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .tck_pin(tck_pin), .tms_pin(tms_pin),
  .tdo(tdo), .tdo_oe_n(tdo_oe_n), .ring_drive_data(ring_drive_data),
  .ring_drive_en(ring_drive_en), .mem_out_hiz(mem_out_hiz), .active_instr(active_instr)
);

// file: dv/bst_scan_host.sv
// external scan controller model: test clock, mode select, data in, reads data out
`timescale 1ns/10ps
module bst_scan_host (
  input wire logic clk_sys,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  output logic tck_pin,
  output logic tms_pin,
  output logic tdi_pin
);
  logic odd;
  initial begin
    tck_pin = 1'b0;
    tms_pin = 1'b1;
    tdi_pin = 1'b1;
    odd = 1'b0;
  end
  // one test clock period of 12 or 13 system clocks, 125 ns on average
  task automatic tap_bit(input logic m, input logic d, output logic o, output logic oe);
    repeat (3) @(posedge clk_sys);
    tms_pin <= m;
    tdi_pin <= d;
    repeat (3) @(posedge clk_sys);
    o = tdo;
    oe = tdo_oe_n;
    tck_pin <= 1'b1;
    odd <= ~odd;
    repeat (odd ? 7 : 6) @(posedge clk_sys);
    tck_pin <= 1'b0;
  endtask
  // idle to shift, n bits lsb first, back to idle; tdi idles high like the pull-up
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output logic ok);
    logic o, oe;
    dout = '0;
    ok = 1'b1;
    tap_bit(1'b1, 1'b1, o, oe);
    if (ir) tap_bit(1'b1, 1'b1, o, oe);
    tap_bit(1'b0, 1'b1, o, oe);
    tap_bit(1'b0, 1'b1, o, oe);
    for (int i = 0; i < n; i++) begin
      tap_bit(i == n - 1, din[i], o, oe);
      dout[i] = o;
      ok &= !oe;
    end
    tap_bit(1'b1, 1'b1, o, oe);
    tap_bit(1'b0, 1'b1, o, oe);
  endtask
  task automatic reset_tap();
    logic o, oe;
    repeat (5) tap_bit(1'b1, 1'b1, o, oe);
    tap_bit(1'b0, 1'b1, o, oe);
  endtask
endmodule

// file: dv/tb_boundary_scan_tap.sv
// self-checking bench: scans through the test port and memory-side pin checks
`timescale 1ns/10ps
module tb_boundary_scan_tap;
  logic clk_sys, sys_rst, tck_pin, tms_pin, tdi_pin, tdo, tdo_oe_n;
  logic ring_drive_en, mem_out_hiz, ok, b, oe;
  logic [5:0] mem_pin_lvl, ring_drive_data;
  logic [2:0] active_instr;
  logic [31:0] got;
  logic [2:0] bp_codes [4] = '{bst_pkg::INS_RESERVED_BYPASS_ALIAS_A, bst_pkg::INS_BYPASS,
    bst_pkg::INS_PRIVATE_VENDOR_INSTRUCTION, bst_pkg::INS_RESERVED_BYPASS_ALIAS_B};
  int n_fail = 0;
  int n_compared = 0;
  bst_boundary_scan_tap #(.RING_LEN(8), .PIN_CELLS(6)) uut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .tck_pin(tck_pin), .tms_pin(tms_pin),
    .tdi_pin(tdi_pin), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .mem_pin_lvl(mem_pin_lvl),
    .ring_drive_data(ring_drive_data), .ring_drive_en(ring_drive_en),
    .mem_out_hiz(mem_out_hiz), .active_instr(active_instr)
  );
  bst_scan_host host (
    .clk_sys(clk_sys), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .tck_pin(tck_pin),
    .tms_pin(tms_pin), .tdi_pin(tdi_pin)
  );
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] g, e, input string s);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, s, g, e);
    end
  endtask
  task automatic test_done();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic load_ir(input logic [2:0] code);
    host.scan(1'b1, 3, {29'h0, code}, got, ok);
    chk(got[1:0], bst_pkg::IR_CAPTURE_LOW, "ir capture");
    chk(ok, 1'b1, "tdo enable in shift");
    chk(active_instr, code, "active instr");
  endtask
  // hang guard well above the longest sequence
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    test_done();
  end
  initial begin
    sys_rst = 1'b1;
    mem_pin_lvl = 6'h2D;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (30) @(posedge clk_sys);
    chk(active_instr, bst_pkg::INS_IDCODE, "power-up instr");
    chk({tdo_oe_n, ring_drive_en, mem_out_hiz}, 3'b100, "idle pins");
    $display("test reset done");
    host.reset_tap();
    host.scan(1'b0, 32, 32'hFFFF_FFFF, got, ok);
    chk(got, {20'h0, bst_pkg::ID_VENDOR_DEF, 1'b1}, "id word");
    chk(ok, 1'b1, "tdo enable in shift");
    $display("test idcode done");
    foreach (bp_codes[i]) begin
      load_ir(bp_codes[i]);
      host.scan(1'b0, 4, 32'h6, got, ok);
      chk(got, 32'hC, "bypass delay");
    end
    $display("test bypass done");
    load_ir(bst_pkg::INS_SAMPLE_PRELOAD);
    host.scan(1'b0, 8, 32'hA5, got, ok);
    chk(got, 32'hED, "sample capture");
    $display("test sample done");
    load_ir(bst_pkg::INS_EXTEST);
    chk({ring_drive_en, ring_drive_data}, 7'h65, "extest drive");
    mem_pin_lvl <= 6'h12;
    host.scan(1'b0, 8, 32'h0, got, ok);
    chk(got, 32'hD2, "extest capture");
    $display("test extest done");
    load_ir(bst_pkg::INS_SAMPLE_HIZ);
    chk({mem_out_hiz, ring_drive_en}, 2'b10, "hiz pins");
    host.scan(1'b0, 8, 32'h0, got, ok);
    chk(got, 32'hD2, "hiz capture");
    $display("test hiz done");
    host.tap_bit(1'b1, 1'b1, b, oe);
    host.tap_bit(1'b0, 1'b1, b, oe);
    host.tap_bit(1'b0, 1'b1, b, oe);
    host.reset_tap();
    chk({active_instr, mem_out_hiz, tdo_oe_n}, 5'b00101, "forced reset");
    $display("test forced reset done");
    test_done();
  end
endmodule
